//--- verilog/arb_defines.svh
// Register offsets, field positions, reset values and clamp codes of the result bank
`ifndef ARB_DEFINES_SVH
`define ARB_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the serial control bus)
// ----------------------------------------------------------------
`define ARB_OFS_IBAT      8'h2A
`define ARB_OFS_VBUS      8'h2C
`define ARB_OFS_VPMID     8'h2E
`define ARB_OFS_VBAT      8'h30
`define ARB_OFS_VSYS      8'h32
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARB_IBAT_LSB      2
`define ARB_IBAT_W        14
`define ARB_BUS_LSB       2
`define ARB_BUS_W         13
`define ARB_CELL_LSB      1
`define ARB_CELL_W        12
// ----------------------------------------------------------------
// Reset value and clamp codes
// ----------------------------------------------------------------
`define ARB_RESET_VAL     16'h0000
`define ARB_IBAT_MIN      14'h38AD
`define ARB_IBAT_MAX      14'h03E8
`define ARB_IBAT_ABORT    14'h2000
`define ARB_BUS_MAX       13'h1388
`define ARB_CELL_MAX      12'hAF0
`endif

//--- verilog/arb_pkg.sv
// Types shared by the result bank
`default_nettype none
package arb_pkg;
    // Channel index of the conversion that completes
    typedef enum logic [2:0] {
        ARB_CH_IBAT,
        ARB_CH_VBUS,
        ARB_CH_VPMID,
        ARB_CH_VBAT,
        ARB_CH_VSYS
    } arb_chan_type;
endpackage : arb_pkg
`default_nettype wire

//--- verilog/arb_result_reg.sv
// One 16-bit result register with clamping and whole-word update
`timescale 1ns/1ps
`default_nettype none
module arb_result_reg #(
    parameter int W      = 13,  // Field width
    parameter int LSB    = 2,   // Field position
    parameter int SIGNED = 0,   // Two's complement field
    parameter logic [W-1:0] MAXC = '1,  // High clamp code
    parameter logic [W-1:0] MINC = '0   // Low clamp code (signed only)
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,      // Completed conversion
    input  wire logic [W-1:0] raw,       // Raw converter code
    input  wire logic         force_val, // Forced load
    input  wire logic [W-1:0] fval,      // Forced field value
    output logic      [15:0]  word       // Register image
);
    logic [W-1:0] fld_q;  // Stored field
    logic [W-1:0] fld_d;  // Next field
    logic [W-1:0] clip;   // Clamped raw
    // ----------------------------------------------------------------
    // Clamping
    // ----------------------------------------------------------------
    always_comb begin
        clip = raw;
        if (SIGNED != 0) begin
            // Signed compare so both ends clamp correctly
            if ($signed(raw) > $signed(MAXC)) begin
                clip = MAXC;
            end else if ($signed(raw) < $signed(MINC)) begin
                clip = MINC;
            end
        end else if (raw > MAXC) begin
            clip = MAXC;
        end
    end
    // ----------------------------------------------------------------
    // Next value: force wins, otherwise hold between conversions
    // ----------------------------------------------------------------
    always_comb begin
        fld_d = fld_q;
        if (force_val) begin
            fld_d = fval;
        end else if (load) begin
            fld_d = clip;
        end
    end
    // Whole field in one edge, so no half-updated word is visible
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fld_q <= '0;
        end else begin
            fld_q <= fld_d;
        end
    end
    // Reserved bits read zero
    always_comb begin
        word = 16'h0000;
        word[LSB +: W] = fld_q;
    end
endmodule : arb_result_reg
`default_nettype wire

//--- verilog/arb_result_bank.sv
// Read-only converter result bank of the charger monitor
// Functional notes
// - Current field bits 15:2, two's complement
// - Current 4 mA step, clamp 38AD/3E8
// - Charge disabled forces current result zero
// - Direction change aborts, field reads 2000
// - Input bus field 14:2, clamp 1388
// - Mid-node field 14:2, clamp 1388
// - Cell field 12:1, clamp AF0
// - All results reset to zero
// - Results hold last value, never self-clear
// - Disabled channel ignores conversions; charge off still zeroes current
`timescale 1ns/1ps
`default_nettype none
`include "arb_defines.svh"
module arb_result_bank (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        conv_done,      // One-cycle conversion completion
    input  wire logic [2:0]  conv_chan,      // Channel of the conversion
    input  wire logic [15:0] conv_code,      // Raw code, low-aligned
    input  wire logic        conv_dir_flip,  // Current changed direction mid-conversion
    input  wire logic        charge_enable,  // Charge enable control
    input  wire logic        battery_current_channel_off,
    input  wire logic        input_bus_channel_off,
    input  wire logic        mid_node_channel_off,
    input  wire logic        cell_channel_off,
    input  wire logic        system_rail_channel_off,
    input  wire logic        reg_rd,         // Register read strobe
    input  wire logic        reg_wr,         // Register write strobe (ignored)
    input  wire logic [7:0]  reg_addr,       // Register byte address
    output logic      [15:0] reg_rdata,      // Read data, registered
    output logic             reg_rvalid      // Read data valid pulse
);
    // ----------------------------------------------------------------
    // Channel decode
    // ----------------------------------------------------------------
    logic ld_ibat, ld_vbus, ld_vpmid, ld_vbat, ld_vsys;
    logic        ibat_force;   // Forced load of current field
    logic [13:0] ibat_fval;    // Forced current code
    logic [15:0] w_ibat, w_vbus, w_vpmid, w_vbat, w_vsys;
    // Completed loads gated by per-channel disables
    always_comb begin
        ld_ibat  = conv_done && conv_chan == 3'(arb_pkg::ARB_CH_IBAT)
                   && !battery_current_channel_off;
        ld_vbus  = conv_done && conv_chan == 3'(arb_pkg::ARB_CH_VBUS)
                   && !input_bus_channel_off;
        ld_vpmid = conv_done && conv_chan == 3'(arb_pkg::ARB_CH_VPMID)
                   && !mid_node_channel_off;
        ld_vbat  = conv_done && conv_chan == 3'(arb_pkg::ARB_CH_VBAT)
                   && !cell_channel_off;
        ld_vsys  = conv_done && conv_chan == 3'(arb_pkg::ARB_CH_VSYS)
                   && !system_rail_channel_off;
    end
    // ----------------------------------------------------------------
    // Current special cases: charge off beats abort code
    // ----------------------------------------------------------------
    always_comb begin
        ibat_force = 1'b0;
        ibat_fval  = 14'h0000;
        if (!charge_enable) begin
            ibat_force = 1'b1;
            ibat_fval  = 14'h0000;
        end else if (ld_ibat && conv_dir_flip) begin
            ibat_force = 1'b1;
            ibat_fval  = `ARB_IBAT_ABORT;
        end
    end
    // ----------------------------------------------------------------
    // Result registers
    // ----------------------------------------------------------------
    // Battery current, signed with clamps on both ends
    arb_result_reg #(.W(`ARB_IBAT_W), .LSB(`ARB_IBAT_LSB), .SIGNED(1),
        .MAXC(`ARB_IBAT_MAX), .MINC(`ARB_IBAT_MIN)) u_ibat (
        .clk       (clk),
        .rst       (rst),
        .load      (ld_ibat),
        .raw       (conv_code[13:0]),
        .force_val (ibat_force),
        .fval      (ibat_fval),
        .word      (w_ibat)
    );
    // Input bus voltage
    arb_result_reg #(.W(`ARB_BUS_W), .LSB(`ARB_BUS_LSB), .SIGNED(0),
        .MAXC(`ARB_BUS_MAX), .MINC(13'h0000)) u_vbus (
        .clk       (clk),
        .rst       (rst),
        .load      (ld_vbus),
        .raw       (conv_code[12:0]),
        .force_val (1'b0),
        .fval      (13'h0000),
        .word      (w_vbus)
    );
    // Mid-node voltage
    arb_result_reg #(.W(`ARB_BUS_W), .LSB(`ARB_BUS_LSB), .SIGNED(0),
        .MAXC(`ARB_BUS_MAX), .MINC(13'h0000)) u_vpmid (
        .clk       (clk),
        .rst       (rst),
        .load      (ld_vpmid),
        .raw       (conv_code[12:0]),
        .force_val (1'b0),
        .fval      (13'h0000),
        .word      (w_vpmid)
    );
    // Cell voltage
    arb_result_reg #(.W(`ARB_CELL_W), .LSB(`ARB_CELL_LSB), .SIGNED(0),
        .MAXC(`ARB_CELL_MAX), .MINC(12'h000)) u_vbat (
        .clk       (clk),
        .rst       (rst),
        .load      (ld_vbat),
        .raw       (conv_code[11:0]),
        .force_val (1'b0),
        .fval      (12'h000),
        .word      (w_vbat)
    );
    // System rail voltage, same layout as the cell channel
    arb_result_reg #(.W(`ARB_CELL_W), .LSB(`ARB_CELL_LSB), .SIGNED(0),
        .MAXC(`ARB_CELL_MAX), .MINC(12'h000)) u_vsys (
        .clk       (clk),
        .rst       (rst),
        .load      (ld_vsys),
        .raw       (conv_code[11:0]),
        .force_val (1'b0),
        .fval      (12'h000),
        .word      (w_vsys)
    );
    // ----------------------------------------------------------------
    // Read port; writes never reach any register
    // ----------------------------------------------------------------
    logic [15:0] rdata_d;   // Next read data
    logic        rvalid_d;  // Next valid
    always_comb begin
        rdata_d  = 16'h0000;
        rvalid_d = reg_rd;
        case (reg_addr)
            `ARB_OFS_IBAT:  rdata_d = w_ibat;
            `ARB_OFS_VBUS:  rdata_d = w_vbus;
            `ARB_OFS_VPMID: rdata_d = w_vpmid;
            `ARB_OFS_VBAT:  rdata_d = w_vbat;
            `ARB_OFS_VSYS:  rdata_d = w_vsys;
            default:        rdata_d = 16'h0000;
        endcase
        if (!reg_rd) begin
            rdata_d = reg_rdata;  // Hold last answer
        end
    end
    // Whole word sampled at once for the host
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= `ARB_RESET_VAL;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= rdata_d;
            reg_rvalid <= rvalid_d;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    chg_off_zero_a: assert property (@(posedge clk) disable iff (rst)
        !charge_enable |=> w_ibat == 16'h0000) else $error("current not cleared");
    abort_code_a: assert property (@(posedge clk) disable iff (rst)
        charge_enable && ld_ibat && conv_dir_flip |=> w_ibat == 16'h8000)
        else $error("abort code wrong");
    ibat_low_bits_a: assert property (@(posedge clk) disable iff (rst)
        w_ibat[1:0] == 2'h0) else $error("current low bits set");
    ibat_clamp_a: assert property (@(posedge clk) disable iff (rst)
        charge_enable && ld_ibat && !conv_dir_flip
        && $signed(conv_code[13:0]) > $signed(14'h03E8)
        |=> w_ibat == 16'h0FA0) else $error("current high clamp");
    vbus_clamp_a: assert property (@(posedge clk) disable iff (rst)
        ld_vbus && conv_code[12:0] > 13'h1388 |=> w_vbus == 16'h4E20)
        else $error("bus clamp");
    vpmid_rsv_a: assert property (@(posedge clk) disable iff (rst)
        w_vpmid[15] == 1'b0 && w_vpmid[1:0] == 2'h0) else $error("mid reserved");
    vbat_clamp_a: assert property (@(posedge clk) disable iff (rst)
        ld_vbat && conv_code[11:0] > 12'hAF0 |=> w_vbat == 16'h15E0)
        else $error("cell clamp");
    hold_value_a: assert property (@(posedge clk) disable iff (rst)
        !ld_vbus |=> $stable(w_vbus)) else $error("bus result changed");
    read_data_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == 8'h30 |=> reg_rvalid && reg_rdata == $past(w_vbat))
        else $error("read data wrong");
    // ----------------------------------------------------------------
    // Load, hold and read-port checks per channel
    // ----------------------------------------------------------------
    // Current holds between its own loads while charging
    ibat_hold_a: assert property (@(posedge clk) disable iff (rst)
        charge_enable && !ld_ibat |=> $stable(w_ibat))
        else $error("current result changed");
    // In-range current lands unclamped, shifted into bits 15:2
    ibat_load_a: assert property (@(posedge clk) disable iff (rst)
        charge_enable && ld_ibat && !conv_dir_flip
        && $signed(conv_code[13:0]) <= $signed(`ARB_IBAT_MAX)
        && $signed(conv_code[13:0]) >= $signed(`ARB_IBAT_MIN)
        |=> w_ibat == {$past(conv_code[13:0]), 2'b00}) else $error("current load wrong");
    // Deep discharge codes pin at the low clamp
    ibat_low_clamp_a: assert property (@(posedge clk) disable iff (rst)
        charge_enable && ld_ibat && !conv_dir_flip
        && $signed(conv_code[13:0]) < $signed(`ARB_IBAT_MIN)
        |=> w_ibat == {`ARB_IBAT_MIN, 2'b00}) else $error("current low clamp");
    // In-range mid-node code lands unclamped in bits 14:2
    mid_load_a: assert property (@(posedge clk) disable iff (rst)
        ld_vpmid && conv_code[12:0] <= `ARB_BUS_MAX
        |=> w_vpmid == {1'b0, $past(conv_code[12:0]), 2'b00}) else $error("mid load wrong");
    // A completion on the input bus channel while it is disabled must leave its word alone
    bus_off_a: assert property (@(posedge clk) disable iff (rst)
        conv_done && conv_chan == 3'(arb_pkg::ARB_CH_VBUS) && input_bus_channel_off
        |=> $stable(w_vbus)) else $error("disabled bus loaded");
    // Voltage words only move on their own loads
    mid_hold_a: assert property (@(posedge clk) disable iff (rst)
        !ld_vpmid |=> $stable(w_vpmid)) else $error("mid result changed");
    cell_hold_a: assert property (@(posedge clk) disable iff (rst)
        !ld_vbat |=> $stable(w_vbat)) else $error("cell result changed");
    rail_hold_a: assert property (@(posedge clk) disable iff (rst)
        !ld_vsys |=> $stable(w_vsys)) else $error("rail result changed");
    // Reserved bits of the voltage words stay clear
    bus_rsv_a: assert property (@(posedge clk) disable iff (rst)
        w_vbus[15] == 1'b0 && w_vbus[1:0] == 2'h0 && w_vbat[15:13] == 3'h0
        && w_vbat[0] == 1'b0 && w_vsys[15:13] == 3'h0 && w_vsys[0] == 1'b0)
        else $error("reserved bits set");
    // Valid follows each read strobe by exactly one cycle
    rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
        reg_rvalid == $past(reg_rd)) else $error("read valid misplaced");
    // Holes in the map answer zero, never a stale word
    unmapped_zero_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && !(reg_addr inside {`ARB_OFS_IBAT, `ARB_OFS_VBUS, `ARB_OFS_VPMID,
        `ARB_OFS_VBAT, `ARB_OFS_VSYS}) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    // A host write must not disturb the read port
    write_ignored_a: assert property (@(posedge clk) disable iff (rst)
        reg_wr && !reg_rd |=> $stable(reg_rdata) && !reg_rvalid)
        else $error("write disturbed read port");
endmodule : arb_result_bank
`default_nettype wire

//--- testbench/arb_host_model.sv
// Host software model: reads and writes on the register strobes
`timescale 1ns/1ps
`default_nettype none
module arb_host_model (
    input  wire logic        clk,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [7:0]  reg_addr,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // Idle bus at time zero
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
    end
    // One strobe for one edge; address parked as junk once released
    task automatic strobe(input logic [7:0] a, input logic wr);
        @(posedge clk);
        reg_rd <= !wr;
        reg_wr <= wr;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        reg_addr <= ~a;
    endtask : strobe
    // Read: answer comes exactly one cycle after the taking edge
    task automatic read(input logic [7:0] a, output logic [15:0] d, output logic ok);
        strobe(a, 1'b0);
        @(posedge clk);
        ok = reg_rvalid;
        d = reg_rdata;
    endtask : read
endmodule : arb_host_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the converter result bank
`timescale 1ns/1ps
`default_nettype none
`include "arb_defines.svh"
module tb_top;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic        clk, rst, conv_done, conv_dir_flip, charge_enable;
    logic        reg_rd, reg_wr, reg_rvalid;
    logic [2:0]  conv_chan;
    logic [4:0]  off;           // Channel disables, index = channel
    logic [7:0]  reg_addr;
    logic [15:0] conv_code, reg_rdata;
    logic [15:0] last [5];      // Last expected word per channel
    logic [7:0]  ofs [5] = '{`ARB_OFS_IBAT, `ARB_OFS_VBUS, `ARB_OFS_VPMID,
                             `ARB_OFS_VBAT, `ARB_OFS_VSYS};
    int          errors, cmp_count, cycles;

    arb_result_bank u_dut (.clk(clk), .rst(rst), .conv_done(conv_done),
        .conv_chan(conv_chan), .conv_code(conv_code), .conv_dir_flip(conv_dir_flip),
        .charge_enable(charge_enable), .battery_current_channel_off(off[0]),
        .input_bus_channel_off(off[1]), .mid_node_channel_off(off[2]),
        .cell_channel_off(off[3]), .system_rail_channel_off(off[4]),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    arb_host_model u_host (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // 40 MHz clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    // Hang guard: whole run is under two hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Read one register, answer must come flagged valid
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        u_host.read(a, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask : rc
    // One completed conversion
    task automatic conv(input int ch, input logic [15:0] code, input logic flip);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_chan <= 3'(ch);
        conv_code <= code;
        conv_dir_flip <= flip;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_dir_flip <= 1'b0;
    endtask : conv
    // Convert, then read straight back: the word must be whole and new
    task automatic lc(input int ch, input logic [15:0] code, input logic flip,
                      input logic [15:0] exp);
        conv(ch, code, flip);
        rc(ofs[ch], exp);
        last[ch] = exp;
    endtask : lc
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 5; i++) rc(ofs[i], `ARB_RESET_VAL);
        rc(8'h34, 16'h0000);
    endtask : t_reset
    task automatic t_current();
        lc(0, 16'h0064, 1'b0, 16'h0190);
        lc(0, 16'h3FFF, 1'b0, 16'hFFFC);
        lc(0, 16'h1000, 1'b0, {`ARB_IBAT_MAX, 2'b00});
        lc(0, 16'h2000, 1'b0, {`ARB_IBAT_MIN, 2'b00});
        lc(0, 16'h0001, 1'b1, 16'h8000);
    endtask : t_current
    // Charge off wipes the abort code and blocks new results
    task automatic t_charge_off();
        @(posedge clk);
        charge_enable <= 1'b0;
        rc(ofs[0], 16'h0000);
        lc(0, 16'h0010, 1'b0, 16'h0000);
        @(posedge clk);
        charge_enable <= 1'b1;
        lc(0, 16'h0010, 1'b0, 16'h0040);
    endtask : t_charge_off
    // Over-range raw codes with junk in the upper bits on bus and cell, in-range codes on mid-node and rail
    task automatic t_voltages();
        lc(1, 16'hFFFF, 1'b0, {1'b0, `ARB_BUS_MAX, 2'b00});
        lc(2, 16'h0123, 1'b0, 16'h048C);
        lc(3, 16'hFFFF, 1'b0, {3'b000, `ARB_CELL_MAX, 1'b0});
        lc(4, 16'h0100, 1'b0, 16'h0200);
    endtask : t_voltages
    // Writes ignored, idle time does not clear the mid-node word
    task automatic t_hold();
        u_host.strobe(ofs[2], 1'b1);
        repeat (30) @(posedge clk);
        rc(ofs[2], last[2]);
        rc(ofs[2], last[2]);
    endtask : t_hold
    // Each disabled channel keeps its old word
    task automatic t_disable();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            off <= 5'(1 << i);
            conv(i, 16'h0005, 1'b0);
            rc(ofs[i], last[i]);
        end
        @(posedge clk);
        off <= 5'h00;
    endtask : t_disable
    // ----------------------------------------------------------------
    // Verdict and main sequence
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    initial begin
        {rst, conv_done, conv_dir_flip, charge_enable} = 4'b1001;
        {conv_chan, conv_code, off} = '0;
        {errors, cmp_count, cycles} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_current();
        t_charge_off();
        t_voltages();
        t_hold();
        t_disable();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
